// [hw/sbx_exec.sv]
`timescale 1ns/10ps
`include "sbx_regs.svh"
module sbx_exec (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               resetn,
    // Instruction issue from the sequencer
    input  wire logic               issue,
    input  wire sbx_pkg::sbx_op_type op,
    input  wire logic [7:0]         working_register,
    input  wire logic [7:0]         mem_rdata,
    input  wire logic [7:0]         status_in,
    // Memory write-back
    output logic                    mem_we,
    output logic [7:0]              mem_wdata,
    // Status write-back
    output logic                    status_we,
    output logic [7:0]              status_out,
    // Sequencer control
    output logic                    squash_next,
    output logic                    busy
);
    import sbx_pkg::*;

    sbx_state_type   state;
    sbx_state_type   next_state;
    wire logic [7:0] add_sum;
    wire logic       add_cout;
    wire logic       add_hc;
    wire logic       add_ov;
    wire logic [7:0] dec_val;
    wire logic       dec_zero;
    wire logic       take_sub;
    wire logic       take_dec;
    wire logic [7:0] next_status;
    wire logic [7:0] next_wdata;
    wire logic [8:0] ref_wide;
    wire logic [4:0] ref_low;
    logic [1:0]      dec_len;

    // Issue is ignored while the dummy cycle runs
    assign take_sub = issue && (op == SBX_OP_SUB_MEM) && (state == SBX_ST_RUN);
    assign take_dec = issue && (op == SBX_OP_DEC_SKIP) && (state == SBX_ST_RUN);

    // Subtraction as addition of the complement
    sbx_adder u_adder (
        .a     (working_register),
        .b     (~mem_rdata),
        .cin   (status_in[`SBX_C_BIT]),
        .sum   (add_sum),
        .cout  (add_cout),
        .hcout (add_hc),
        .ovf   (add_ov)
    );

    // Decrement and the zero test share one value
    assign dec_val  = mem_rdata - 8'h01;
    assign dec_zero = (dec_val == 8'h00);

    // Flag merge keeps the upper four bits as they were
    assign next_status = {status_in[`SBX_UB_BIT:`SBX_PD_BIT], add_ov, (add_sum == 8'h00), add_hc, add_cout};
    assign next_wdata  = take_sub ? add_sum : dec_val;

    // Dummy cycle only after a zero decrement; a dummy never chains into another
    always_comb begin
        next_state = SBX_ST_RUN;
        unique case (state)
            SBX_ST_RUN: begin
                if (take_dec && dec_zero) begin
                    next_state = SBX_ST_DUMMY;
                end else begin
                    next_state = SBX_ST_RUN;
                end
            end
            SBX_ST_DUMMY: begin
                next_state = SBX_ST_RUN;
            end
        endcase
    end

    // Write-back registers; the working register is never driven here
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mem_we     <= 1'b0;
            mem_wdata  <= `SBX_RST_BYTE;
            status_we  <= 1'b0;
            status_out <= `SBX_RST_BYTE;
        end else begin
            mem_we     <= take_sub || take_dec;
            mem_wdata  <= next_wdata;
            status_we  <= take_sub;
            status_out <= next_status;
        end
    end

    // Skip sequencing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state       <= SBX_ST_RUN;
            squash_next <= 1'b0;
            busy        <= 1'b0;
        end else begin
            state       <= next_state;
            squash_next <= (next_state == SBX_ST_DUMMY);
            busy        <= (next_state == SBX_ST_DUMMY);
        end
    end

    // Reference sums built apart from the adder, read only by the checks below
    // Kept separate so a wiring slip in the adder cannot hide in its own check
    assign ref_wide = {1'b0, working_register} + {1'b0, ~mem_rdata} + {8'h00, status_in[`SBX_C_BIT]};
    assign ref_low  = {1'b0, working_register[3:0]} + {1'b0, ~mem_rdata[3:0]} + {4'h0, status_in[`SBX_C_BIT]};

    // Machine cycles of the decrement in flight, for the length checks
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dec_len <= 2'h0;
        end else if (take_dec) begin
            dec_len <= 2'h1;
        end else if (state == SBX_ST_DUMMY) begin
            dec_len <= dec_len + 2'h1;
        end else begin
            dec_len <= 2'h0;
        end
    end

    // Subtract-to-memory checks
    // Operands are taken one cycle back, as the write-back is registered
    a_sub_result: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> mem_we && mem_wdata == 8'($past(working_register) + ~$past(mem_rdata)
            + {7'h0, $past(status_in[`SBX_C_BIT])}))
        else $error("subtract result wrong");
    a_sub_upper_kept: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> status_we && status_out[7:4] == $past(status_in[7:4]))
        else $error("upper bits changed");
    a_sub_zero_flag: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> status_out[`SBX_Z_BIT] == (mem_wdata == 8'h00))
        else $error("zero flag wrong");
    a_sub_carry_flag: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> status_out[`SBX_C_BIT] == $past(ref_wide[8]))
        else $error("carry flag wrong");
    a_sub_nibble_flag: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> status_out[`SBX_AC_BIT] == $past(ref_low[4]))
        else $error("nibble flag wrong");
    a_sub_range_flag: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> status_out[`SBX_OV_BIT] ==
            (($past(working_register[7]) != $past(mem_rdata[7]))
            && ($past(ref_wide[7]) != $past(working_register[7]))))
        else $error("range flag wrong");
    a_sub_no_skip: assert property (@(posedge mclk) disable iff (!resetn)
        take_sub |=> !squash_next && !busy)
        else $error("subtract skipped");
    a_flags_need_sub: assert property (@(posedge mclk) disable iff (!resetn)
        status_we |-> $past(issue) && $past(op) == SBX_OP_SUB_MEM)
        else $error("flags written without subtract");

    // Decrement checks
    a_dec_written: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec |=> mem_we && mem_wdata == 8'($past(mem_rdata) - 8'h01))
        else $error("decrement wrong");
    a_dec_no_flags: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec |=> !status_we)
        else $error("decrement touched flags");
    a_dec_wrap: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec && mem_rdata == 8'h00 |=> mem_wdata == 8'hFF && !squash_next)
        else $error("wrap handled wrong");
    a_write_needs_issue: assert property (@(posedge mclk) disable iff (!resetn)
        mem_we |-> $past(issue))
        else $error("write without issue");

    // Skip checks
    // The dummy cycle must never accept a write, or the suppressed instruction leaks
    a_skip_on_zero: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec && mem_rdata == 8'h01 |=> squash_next ##1 !squash_next)
        else $error("skip missing");
    a_skip_same_value: assert property (@(posedge mclk) disable iff (!resetn)
        squash_next |-> mem_we && mem_wdata == 8'h00)
        else $error("skip on wrong value");
    a_zero_write_skip: assert property (@(posedge mclk) disable iff (!resetn)
        mem_we && !status_we && mem_wdata == 8'h00 |-> squash_next)
        else $error("zero decrement not skipped");
    a_no_skip_nonzero: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec && mem_rdata != 8'h01 |=> !squash_next)
        else $error("spurious skip");
    a_dummy_blocks: assert property (@(posedge mclk) disable iff (!resetn)
        busy |=> !mem_we && !squash_next)
        else $error("issue during dummy");
    a_squash_pulse: assert property (@(posedge mclk) disable iff (!resetn)
        squash_next |=> !squash_next)
        else $error("squash too long");
    a_len_skip: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(busy) |-> dec_len == 2'(`SBX_SKIP_CYCLES))
        else $error("skip length wrong");
    a_len_single: assert property (@(posedge mclk) disable iff (!resetn)
        take_dec && !dec_zero |=> dec_len == 2'h1 && !busy)
        else $error("single length wrong");

    // Idle checks
    a_idle_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        !take_sub && !take_dec |=> !mem_we && !status_we)
        else $error("write while idle");
    a_op_none: assert property (@(posedge mclk) disable iff (!resetn)
        issue && op == SBX_OP_NONE |=> !mem_we && !status_we)
        else $error("empty op wrote");

    // Main scenarios
    c_sub: cover property (@(posedge mclk) disable iff (!resetn) take_sub);
    c_issue_in_dummy: cover property (@(posedge mclk) disable iff (!resetn) busy && issue);
    c_skip: cover property (@(posedge mclk) disable iff (!resetn) take_dec && dec_zero);
    c_noskip: cover property (@(posedge mclk) disable iff (!resetn) take_dec && !dec_zero);
    c_wrap: cover property (@(posedge mclk) disable iff (!resetn) take_dec && mem_rdata == 8'h00);
endmodule

// [pkg/sbx_regs.svh]
`ifndef SBX_REGS_SVH
`define SBX_REGS_SVH
// Status register bit positions
`define SBX_C_BIT   0
`define SBX_AC_BIT  1
`define SBX_Z_BIT   2
`define SBX_OV_BIT  3
`define SBX_PD_BIT  4
`define SBX_TO_BIT  5
`define SBX_UA_BIT  6
`define SBX_UB_BIT  7
// Reset values
`define SBX_RST_BYTE 8'h00
// Timing: machine cycles of the skip instruction
`define SBX_SKIP_CYCLES 2
`endif

// [pkg/sbx_pkg.sv]
package sbx_pkg;
    typedef enum logic [1:0] {
        SBX_OP_NONE,
        SBX_OP_SUB_MEM,
        SBX_OP_DEC_SKIP
    } sbx_op_type;
    typedef enum logic {
        SBX_ST_RUN,
        SBX_ST_DUMMY
    } sbx_state_type;
endpackage

// [hw/sbx_adder.sv]
`timescale 1ns/10ps
// Eight-bit adder with nibble and full carries and signed overflow
module sbx_adder (
    // Operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    // Results
    output logic [7:0]      sum,
    output logic            cout,
    output logic            hcout,
    output logic            ovf
);
    wire logic [4:0] low_sum;
    wire logic [4:0] high_sum;
    // Split at the nibble so the half carry comes out naturally
    assign low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign high_sum = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_sum[4]};
    assign sum      = {high_sum[3:0], low_sum[3:0]};
    assign cout     = high_sum[4];
    assign hcout    = low_sum[4];
    assign ovf      = (a[7] == b[7]) && (sum[7] != a[7]);
endmodule

// [tb/sbx_mem_model.sv]
`timescale 1ns/10ps
// Data byte and status byte as the sequencer sees them
module sbx_mem_model (
    // Clock and preload
    input  wire logic       mclk,
    input  wire logic       load,
    input  wire logic [7:0] load_mem,
    input  wire logic [7:0] load_status,
    // Write-back from the block
    input  wire logic       mem_we,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       status_we,
    input  wire logic [7:0] status_out,
    // Operand bytes
    output logic [7:0]      mem,
    output logic [7:0]      status
);
    // Preload wins so a scenario starts from known bytes
    always_ff @(posedge mclk) begin
        if (load) begin
            mem    <= load_mem;
            status <= load_status;
        end else begin
            if (mem_we) mem <= mem_wdata;
            if (status_we) status <= status_out;
        end
    end
endmodule

// [tb/test_subtract_and_skip_exec.sv]
`timescale 1ns/10ps
module test_subtract_and_skip_exec;
    import sbx_pkg::*;
    logic       mclk, resetn, issue, load, mem_we, status_we, squash_next, busy;
    sbx_op_type op;
    logic [7:0] w, ld_m, ld_s, mem, status, mem_wdata, status_out;
    int         n_fail, tests_run;
    sbx_exec uut (.mclk(mclk), .resetn(resetn), .issue(issue), .op(op), .working_register(w),
        .mem_rdata(mem), .status_in(status), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .status_we(status_we), .status_out(status_out), .squash_next(squash_next), .busy(busy));
    sbx_mem_model mdl (.mclk(mclk), .load(load), .load_mem(ld_m), .load_status(ld_s),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .status_we(status_we), .status_out(status_out),
        .mem(mem), .status(status));
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Preload, then issue; a second issue may follow straight away
    task start(sbx_op_type o, logic [7:0] wv, logic [7:0] mv, logic [7:0] sv, logic again);
        @(posedge mclk); load <= 1'b1; ld_m <= mv; ld_s <= sv;
        @(posedge mclk); load <= 1'b0; issue <= 1'b1; op <= o; w <= wv;
        @(posedge mclk); issue <= again;
        @(negedge mclk);
    endtask
    task t_sub(logic [7:0] wv, logic [7:0] mv, logic [7:0] sv);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, wv} + {1'b0, ~mv} + sv[0];
        h = {1'b0, wv[3:0]} + {1'b0, ~mv[3:0]} + sv[0];
        start(SBX_OP_SUB_MEM, wv, mv, sv, 1'b0);
        chk("mem_we", 8'h01, mem_we);
        chk("mem_wdata", s[7:0], mem_wdata);
        chk("status_we", 8'h01, status_we);
        chk("status_out", {sv[7:4], (wv[7] == ~mv[7]) && (s[7] != wv[7]), s[7:0] == 8'h00, h[4], s[8]},
            status_out);
        $display("sub %h %h %h done", wv, mv, sv);
    endtask
    // Second issue lands in the dummy cycle when the result is nil
    task t_dec(logic [7:0] mv);
        logic [7:0] e;
        e = mv - 8'h01;
        start(SBX_OP_DEC_SKIP, 8'h00, mv, 8'h00, 1'b1);
        chk("dec mem_we", 8'h01, mem_we);
        chk("dec wdata", e, mem_wdata);
        chk("squash", {7'h00, e == 8'h00}, squash_next);
        chk("busy", {7'h00, e == 8'h00}, busy);
        chk("dec status_we", 8'h00, status_we);
        @(posedge mclk); issue <= 1'b0;
        @(negedge mclk);
        chk("next mem_we", {7'h00, e != 8'h00}, mem_we);
        chk("stored", e, mem);
        $display("dec %h done", mv);
    endtask
    // Empty op must leave memory and flags alone
    task t_none;
        start(SBX_OP_NONE, 8'h11, 8'h22, 8'h33, 1'b0);
        chk("none mem_we", 8'h00, mem_we);
        chk("none status_we", 8'h00, status_we);
        $display("none done");
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Watchdog against a hang
    initial begin
        #100us;
        n_fail++;
        report_and_stop();
    end
    initial begin
        resetn = 1'b0; issue = 1'b0; load = 1'b0; op = SBX_OP_NONE;
        w = 8'h00; ld_m = 8'h00; ld_s = 8'h00;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_sub(8'h50, 8'h30, 8'h01);
        t_sub(8'h30, 8'h50, 8'hA1);
        t_sub(8'h80, 8'h01, 8'h01);
        t_sub(8'h10, 8'h10, 8'hF1);
        t_sub(8'h10, 8'h01, 8'h50);
        t_dec(8'h01);
        t_dec(8'h05);
        t_dec(8'h00);
        t_none();
        report_and_stop();
    end
endmodule
